/* hdl/fault_edge_latch.sv */
// Per-bit transition filter and sticky event latch.
// Assumes a synchronised active-low reset and one clock.
`timescale 1ns/1ps
`include "qsr_defs.svh"
module fault_edge_latch (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Link to the register front end
  qsr_edge_if.latch edge_if
);
  qsr_pkg::fault_vec_type event_ff;
  qsr_pkg::fault_vec_type nxt_event;
  qsr_pkg::fault_vec_type rise_hit;
  qsr_pkg::fault_vec_type fall_hit;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  genvar i;
  generate
    for (i = 0; i < `QSR_FAULT_W; i++)
    begin : g_bit
      // Edge seen between two registered samples
      assign rise_hit[i] = edge_if.cond_now[i] & ~edge_if.cond_prev[i]
        & edge_if.rise_filter[i];
      assign fall_hit[i] = ~edge_if.cond_now[i] & edge_if.cond_prev[i]
        & edge_if.fall_filter[i];
      // Set beats clear so an edge during a read is kept
      assign nxt_event[i] = rise_hit[i] | fall_hit[i]
        | (event_ff[i] & ~edge_if.clear_mask[i]);

      property p_rise;
        edge_if.cond_now[i] && !edge_if.cond_prev[i] && edge_if.rise_filter[i]
          |=> event_ff[i];
      endproperty
      a_rise: assert property (p_rise) else $error("rising edge lost");
      property p_fall;
        !edge_if.cond_now[i] && edge_if.cond_prev[i] && edge_if.fall_filter[i]
          |=> event_ff[i];
      endproperty
      a_fall: assert property (p_fall) else $error("falling edge lost");
      property p_none;
        !edge_if.rise_filter[i] && !edge_if.fall_filter[i] && !event_ff[i]
          |=> !event_ff[i];
      endproperty
      a_none: assert property (p_none) else $error("unfiltered bit set");
      property p_hold;
        event_ff[i] && !edge_if.clear_mask[i] |=> event_ff[i] [*1];
      endproperty
      a_hold: assert property (p_hold) else $error("event dropped");
      property p_clear;
        event_ff[i] && edge_if.clear_mask[i] && !rise_hit[i] && !fall_hit[i]
          |=> !event_ff[i];
      endproperty
      a_clear: assert property (p_clear) else $error("read did not clear");
    end
  endgenerate

  // Sticky event register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      event_ff <= `QSR_NO_FAULTS;
    else
      event_ff <= nxt_event;
  end

  assign edge_if.event_bits = event_ff;
endmodule : fault_edge_latch

/* hdl/qsr_defs.svh */
// Constants for the fault status block: select codes, field positions,
// reset values. Assumes inclusion by bare name from the design files.
`ifndef QSR_DEFS_SVH
`define QSR_DEFS_SVH

// Register select codes on the status command port
`define QSR_SEL_OP_EVENT 3'h0
`define QSR_SEL_OP_ENABLE 3'h1
`define QSR_SEL_COND 3'h2
`define QSR_SEL_EVENT 3'h3
`define QSR_SEL_ENABLE 3'h4
`define QSR_SEL_FALL 3'h5
`define QSR_SEL_RISE 3'h6

// Field widths and condition bit positions
`define QSR_FAULT_W 9
`define QSR_WORD_W 16
`define QSR_BIT_OVERVOLTAGE 8
`define QSR_BIT_LINE_INPUT 7
`define QSR_BIT_OVERCURRENT 6
`define QSR_BIT_FAN 5
`define QSR_BIT_SHORT 4
`define QSR_BIT_OVERTEMP 3
`define QSR_BIT_OVERPOWER 2
`define QSR_BIT_DCDC 1
`define QSR_BIT_ACDC 0

// Reset values
`define QSR_RST_ENABLE 9'h000
`define QSR_RST_FALL 9'h000
`define QSR_RST_RISE 9'h1FF
`define QSR_ALL_FAULTS 9'h1FF
`define QSR_NO_FAULTS 9'h000
`define QSR_ZERO_WORD 16'h0000
`define QSR_ZERO_UPPER 7'h00

`endif

/* hdl/qsr_edge_if.sv */
// Carrier between the register front end and the per-bit edge latch.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface qsr_edge_if;
  qsr_pkg::fault_vec_type cond_now;
  qsr_pkg::fault_vec_type cond_prev;
  qsr_pkg::fault_vec_type rise_filter;
  qsr_pkg::fault_vec_type fall_filter;
  qsr_pkg::fault_vec_type clear_mask;
  qsr_pkg::fault_vec_type event_bits;
  modport ctrl (output cond_now, cond_prev, rise_filter, fall_filter, clear_mask,
    input event_bits);
  modport latch (input cond_now, cond_prev, rise_filter, fall_filter, clear_mask,
    output event_bits);
endinterface : qsr_edge_if

/* hdl/qsr_pkg.sv */
// Types shared by the fault status block.
// Assumes the defs header is compiled alongside.
`include "qsr_defs.svh"
package qsr_pkg;
  typedef logic [`QSR_FAULT_W-1:0] fault_vec_type;
  typedef logic [`QSR_WORD_W-1:0] word_type;
  typedef logic [2:0] sel_type;
endpackage : qsr_pkg

/* hdl/questionable_status_reporting.sv */
// Fault status reporting: live condition, filtered event latch, summary bit.
// Assumes fault lines and commands synchronous to clk_in, one command a cycle.
`timescale 1ns/1ps
`include "qsr_defs.svh"
module questionable_status_reporting (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fault detector lines
  input wire logic output_overvoltage_fault_in,
  input wire logic line_input_fault_in,
  input wire logic overcurrent_fault_in,
  input wire logic fan_failure_fault_in,
  input wire logic output_short_fault_in,
  input wire logic overtemperature_fault_in,
  input wire logic overpower_fault_in,
  input wire logic inner_dcdc_stage_fault_in,
  input wire logic inner_acdc_stage_fault_in,
  // Status command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [2:0] cmd_sel_in,
  input wire logic [15:0] cmd_wdata_in,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  // Status byte summary
  input wire logic summary_enable_in,
  output logic fault_summary_bit_out
);
  logic rst_sync1_ff;
  logic rst_sync2_ff;
  logic rst_n;
  qsr_pkg::fault_vec_type fault_vec;
  qsr_pkg::fault_vec_type cond_ff;
  qsr_pkg::fault_vec_type prev_ff;
  qsr_pkg::fault_vec_type mask_ff;
  qsr_pkg::fault_vec_type fall_ff;
  qsr_pkg::fault_vec_type rise_ff;
  qsr_pkg::fault_vec_type nxt_mask;
  qsr_pkg::fault_vec_type nxt_fall;
  qsr_pkg::fault_vec_type nxt_rise;
  qsr_pkg::fault_vec_type wr_field;
  qsr_pkg::fault_vec_type rd_field;
  qsr_pkg::word_type nxt_rsp_data;
  logic rsp_valid_ff;
  qsr_pkg::word_type rsp_data_ff;
  logic summary_ff;
  logic nxt_summary;
  logic rd_cmd;
  logic wr_cmd;
  logic rd_event;
  qsr_edge_if edge_if ();

  // True when a command of the given kind targets the given register
  function automatic logic hits(input logic valid, input logic kind,
    input qsr_pkg::sel_type sel, input qsr_pkg::sel_type code);
    hits = valid & kind & (sel == code);
  endfunction : hits

  // Reset release through two stages; the first stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end
    else
    begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign rst_n = rst_sync2_ff;

  // Fault lines gathered into the condition layout
  assign fault_vec[`QSR_BIT_OVERVOLTAGE] = output_overvoltage_fault_in;
  assign fault_vec[`QSR_BIT_LINE_INPUT] = line_input_fault_in;
  assign fault_vec[`QSR_BIT_OVERCURRENT] = overcurrent_fault_in;
  assign fault_vec[`QSR_BIT_FAN] = fan_failure_fault_in;
  assign fault_vec[`QSR_BIT_SHORT] = output_short_fault_in;
  assign fault_vec[`QSR_BIT_OVERTEMP] = overtemperature_fault_in;
  assign fault_vec[`QSR_BIT_OVERPOWER] = overpower_fault_in;
  assign fault_vec[`QSR_BIT_DCDC] = inner_dcdc_stage_fault_in;
  assign fault_vec[`QSR_BIT_ACDC] = inner_acdc_stage_fault_in;

  // Command decode; writes keep only the nine meaningful bits
  assign rd_cmd = cmd_valid_in & ~cmd_write_in;
  assign wr_cmd = cmd_valid_in & cmd_write_in;
  assign wr_field = cmd_wdata_in[`QSR_FAULT_W-1:0];
  assign rd_event = hits(cmd_valid_in, ~cmd_write_in, cmd_sel_in, `QSR_SEL_EVENT);
  assign nxt_mask = hits(cmd_valid_in, cmd_write_in, cmd_sel_in, `QSR_SEL_ENABLE)
    ? wr_field : mask_ff;
  assign nxt_fall = hits(cmd_valid_in, cmd_write_in, cmd_sel_in, `QSR_SEL_FALL)
    ? wr_field : fall_ff;
  assign nxt_rise = hits(cmd_valid_in, cmd_write_in, cmd_sel_in, `QSR_SEL_RISE)
    ? wr_field : rise_ff;

  // Read selection; the operation pair and unknown selects answer zero
  assign rd_field = (cmd_sel_in == `QSR_SEL_COND) ? cond_ff
    : (cmd_sel_in == `QSR_SEL_EVENT) ? edge_if.event_bits
    : (cmd_sel_in == `QSR_SEL_ENABLE) ? mask_ff
    : (cmd_sel_in == `QSR_SEL_FALL) ? fall_ff
    : (cmd_sel_in == `QSR_SEL_RISE) ? rise_ff
    : `QSR_NO_FAULTS;
  assign nxt_rsp_data = rd_cmd ? {`QSR_ZERO_UPPER, rd_field} : `QSR_ZERO_WORD;

  // Summary uses the held events with the read-clear applied, not this cycle's new edges, so a read-clear drops it at once
  assign nxt_summary = summary_enable_in & (|(edge_if.event_bits & ~edge_if.clear_mask
    & mask_ff));

  // Condition sample and previous sample for edge finding
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cond_ff <= `QSR_NO_FAULTS;
      prev_ff <= `QSR_NO_FAULTS;
    end
    else
    begin
      cond_ff <= fault_vec;
      prev_ff <= cond_ff;
    end
  end

  // Host-writable masks and filters
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_ff <= `QSR_RST_ENABLE;
      fall_ff <= `QSR_RST_FALL;
      rise_ff <= `QSR_RST_RISE;
    end
    else
    begin
      mask_ff <= nxt_mask;
      fall_ff <= nxt_fall;
      rise_ff <= nxt_rise;
    end
  end

  // Answer one cycle after every command; writes answer zero
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= `QSR_ZERO_WORD;
      summary_ff <= 1'b0;
    end
    else
    begin
      rsp_valid_ff <= cmd_valid_in;
      rsp_data_ff <= nxt_rsp_data;
      summary_ff <= nxt_summary;
    end
  end

  // Hand the samples and filters to the edge latch
  assign edge_if.cond_now = cond_ff;
  assign edge_if.cond_prev = prev_ff;
  assign edge_if.rise_filter = rise_ff;
  assign edge_if.fall_filter = fall_ff;
  assign edge_if.clear_mask = rd_event ? `QSR_ALL_FAULTS : `QSR_NO_FAULTS;

  fault_edge_latch u_latch (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .edge_if(edge_if)
  );

  assign rsp_valid_out = rsp_valid_ff;
  assign rsp_data_out = rsp_data_ff;
  assign fault_summary_bit_out = summary_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  property p_op_event_zero;
    cmd_valid_in && !cmd_write_in && cmd_sel_in == `QSR_SEL_OP_EVENT
      |=> rsp_valid_out && rsp_data_out == 16'h0000;
  endproperty
  a_op_event_zero: assert property (p_op_event_zero) else $error("op event nonzero");
  property p_op_enable_zero;
    wr_cmd && cmd_sel_in == `QSR_SEL_OP_ENABLE ##1
      rd_cmd && cmd_sel_in == `QSR_SEL_OP_ENABLE |=> rsp_data_out == 16'h0000;
  endproperty
  a_op_enable_zero: assert property (p_op_enable_zero) else $error("op enable nonzero");
  property p_cond_live;
    ##1 cond_ff == $past(fault_vec) ##0 (rd_cmd && cmd_sel_in == `QSR_SEL_COND)
      |=> rsp_data_out == {7'h00, $past(fault_vec, 2)};
  endproperty
  a_cond_live: assert property (p_cond_live) else $error("condition not live");
  property p_upper_zero;
    rsp_data_out[15:9] == 7'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_summary;
    ##1 fault_summary_bit_out == $past(summary_enable_in
      && (|(edge_if.event_bits & ~edge_if.clear_mask & mask_ff)));
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");
  property p_enable_rw;
    wr_cmd && cmd_sel_in == `QSR_SEL_ENABLE ##1 rd_cmd && cmd_sel_in == `QSR_SEL_ENABLE
      |=> rsp_data_out == {7'h00, $past(cmd_wdata_in[8:0], 2)};
  endproperty
  a_enable_rw: assert property (p_enable_rw) else $error("enable readback wrong");
  property p_fall_rw;
    wr_cmd && cmd_sel_in == `QSR_SEL_FALL ##1 rd_cmd && cmd_sel_in == `QSR_SEL_FALL
      |=> rsp_data_out == {7'h00, $past(cmd_wdata_in[8:0], 2)};
  endproperty
  a_fall_rw: assert property (p_fall_rw) else $error("falling filter readback wrong");
  property p_rise_rw;
    wr_cmd && cmd_sel_in == `QSR_SEL_RISE ##1 rd_cmd && cmd_sel_in == `QSR_SEL_RISE
      |=> rsp_data_out == {7'h00, $past(cmd_wdata_in[8:0], 2)};
  endproperty
  a_rise_rw: assert property (p_rise_rw) else $error("rising filter readback wrong");
  property p_event_ro;
    wr_cmd && cmd_sel_in == `QSR_SEL_EVENT && cond_ff == prev_ff
      |=> edge_if.event_bits == $past(edge_if.event_bits);
  endproperty
  a_event_ro: assert property (p_event_ro) else $error("event written by host");

  c_summary: cover property ($rose(fault_summary_bit_out));
  c_read_clear: cover property (rd_event && (|edge_if.event_bits) ##1
    edge_if.event_bits == 9'h000);
  c_enable_rw: cover property (wr_cmd && cmd_sel_in == `QSR_SEL_ENABLE ##1
    rd_cmd && cmd_sel_in == `QSR_SEL_ENABLE);
endmodule : questionable_status_reporting

/* testbench/testbench.sv */
// Self-checking bench for the fault status block: a cycle model of the
// registers is compared with the answer and summary outputs every cycle.
// Assumes the defs header and package are compiled ahead of this file.
`timescale 1ns/1ps
`include "qsr_defs.svh"
module testbench;
  // Design inputs, all but rst_n given a value in their declarations
  logic clk = 1'b0;
  logic rst_n;
  logic [8:0] fault_v = 9'h000;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [2:0] cmd_sel = 3'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic sum_en = 1'b0;
  // Design outputs
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic sum_bit;
  // Model state
  logic [1:0] sync_ff;
  logic irst;
  logic rd_evt;
  logic [8:0] m_cond, m_prev, m_event, m_mask, m_fall, m_rise, m_edges, m_evnext;
  logic m_rvalid, m_sum;
  logic [15:0] m_rdata;
  logic [31:0] rnd;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'hB0F8;
  int i;

  // 10 MHz clock
  always #50 clk = ~clk;

  questionable_status_reporting u_questionable_status_reporting (
    .clk_in(clk),
    .rst_n_in(rst_n),
    .output_overvoltage_fault_in(fault_v[8]),
    .line_input_fault_in(fault_v[7]),
    .overcurrent_fault_in(fault_v[6]),
    .fan_failure_fault_in(fault_v[5]),
    .output_short_fault_in(fault_v[4]),
    .overtemperature_fault_in(fault_v[3]),
    .overpower_fault_in(fault_v[2]),
    .inner_dcdc_stage_fault_in(fault_v[1]),
    .inner_acdc_stage_fault_in(fault_v[0]),
    .cmd_valid_in(cmd_valid),
    .cmd_write_in(cmd_write),
    .cmd_sel_in(cmd_sel),
    .cmd_wdata_in(cmd_wdata),
    .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data),
    .summary_enable_in(sum_en),
    .fault_summary_bit_out(sum_bit)
  );

  // Model copy of the two-flop reset release
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      sync_ff <= 2'h0;
    else
      sync_ff <= {sync_ff[0], 1'b1};
  assign irst = sync_ff[1];

  // Filtered edges; a read of the event register clears all but new edges
  assign m_edges = (m_cond & ~m_prev & m_rise) | (~m_cond & m_prev & m_fall);
  assign rd_evt = cmd_valid & ~cmd_write & (cmd_sel == `QSR_SEL_EVENT);
  assign m_evnext = rd_evt ? m_edges : (m_event | m_edges);

  function automatic logic [15:0] model_read(input logic [2:0] sel);
    case (sel)
      `QSR_SEL_COND: model_read = {7'h00, m_cond};
      `QSR_SEL_EVENT: model_read = {7'h00, m_event};
      `QSR_SEL_ENABLE: model_read = {7'h00, m_mask};
      `QSR_SEL_FALL: model_read = {7'h00, m_fall};
      `QSR_SEL_RISE: model_read = {7'h00, m_rise};
      default: model_read = 16'h0000;
    endcase
  endfunction : model_read

  // Register model; old filter and mask values apply in a write cycle
  always @(posedge clk or negedge irst)
    if (!irst)
    begin
      m_cond <= `QSR_NO_FAULTS;
      m_prev <= `QSR_NO_FAULTS;
      m_event <= `QSR_NO_FAULTS;
      m_mask <= `QSR_RST_ENABLE;
      m_fall <= `QSR_RST_FALL;
      m_rise <= `QSR_RST_RISE;
      m_rvalid <= 1'b0;
      m_rdata <= 16'h0000;
      m_sum <= 1'b0;
    end
    else
    begin
      m_cond <= fault_v;
      m_prev <= m_cond;
      m_event <= m_evnext;
      // Summary follows the held events one cycle later; a read drops it at once
      m_sum <= sum_en & |((rd_evt ? `QSR_NO_FAULTS : m_event) & m_mask);
      m_rvalid <= cmd_valid;
      m_rdata <= (cmd_valid & ~cmd_write) ? model_read(cmd_sel) : 16'h0000;
      if (cmd_valid & cmd_write)
      begin
        case (cmd_sel)
          `QSR_SEL_ENABLE: m_mask <= cmd_wdata[8:0];
          `QSR_SEL_FALL: m_fall <= cmd_wdata[8:0];
          `QSR_SEL_RISE: m_rise <= cmd_wdata[8:0];
          default: ;
        endcase
      end
    end

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic complete_run();
    $display("TB: counts compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Outputs are settled at the falling edge; a runaway run counts as a mismatch
  always @(negedge clk)
  begin
    cmp_bit(rsp_valid, m_rvalid);
    cmp_word(rsp_data, m_rdata);
    cmp_bit(sum_bit, m_sum);
    cycles++;
    if (cycles > 20000)
    begin
      failures++;
      complete_run();
    end
  end

  // One cycle of stimulus: fault levels plus an optional command
  task automatic drive(input logic [8:0] f, input logic v, input logic w,
                       input logic [2:0] s, input logic [15:0] d);
    @(posedge clk);
    fault_v <= f;
    cmd_valid <= v;
    cmd_write <= w;
    cmd_sel <= s;
    cmd_wdata <= d;
  endtask : drive

  task automatic read_all();
    for (i = 0; i < 8; i++)
      drive(fault_v, 1'b1, 1'b0, i[2:0], 16'h0000);
  endtask : read_all

  initial
  begin
    // Reset leaves unknown at time zero so the asynchronous clear fires at once
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) drive(9'h000, 1'b0, 1'b0, 3'h0, 16'h0000);
    // Reset values, then writes everywhere with bits 15..9 set
    read_all();
    for (i = 0; i < 8; i++)
      drive(9'h000, 1'b1, 1'b1, i[2:0], 16'hFE5A ^ i[15:0]);
    read_all();
    // Both filters clear: toggling faults must leave no event
    drive(9'h000, 1'b1, 1'b1, `QSR_SEL_RISE, 16'h0000);
    drive(9'h000, 1'b1, 1'b1, `QSR_SEL_FALL, 16'h0000);
    drive(9'h000, 1'b1, 1'b1, `QSR_SEL_ENABLE, 16'h01FF);
    sum_en <= 1'b1;
    drive(9'h1FF, 1'b0, 1'b0, 3'h0, 16'h0000);
    drive(9'h000, 1'b0, 1'b0, 3'h0, 16'h0000);
    read_all();
    // Split filters, then event reads back to back while faults toggle
    drive(9'h000, 1'b1, 1'b1, `QSR_SEL_RISE, 16'h0155);
    drive(9'h000, 1'b1, 1'b1, `QSR_SEL_FALL, 16'h00AA);
    for (i = 0; i < 12; i++)
      drive(i[0] ? 9'h1FF : 9'h000, 1'b1, 1'b0, `QSR_SEL_EVENT, 16'h0000);
    // Events held until read, summary follows its enable
    drive(9'h1FF, 1'b0, 1'b0, 3'h0, 16'h0000);
    repeat (4) drive(9'h1FF, 1'b0, 1'b0, 3'h0, 16'h0000);
    sum_en <= 1'b0;
    read_all();
    // Reset in mid-run with faults standing high
    rst_n <= 1'b0;
    repeat (2) drive(9'h1FF, 1'b0, 1'b0, 3'h0, 16'h0000);
    rst_n <= 1'b1;
    repeat (5) drive(9'h1FF, 1'b0, 1'b0, 3'h0, 16'h0000);
    read_all();
    // Random traffic and fault activity
    repeat (3000)
    begin
      rnd = $random(seed);
      if (rnd[31:30] == 2'h0)
        sum_en <= rnd[29];
      drive(rnd[28:27] == 2'h0 ? rnd[8:0] : fault_v, rnd[26], rnd[25] & rnd[24],
            rnd[23:21], rnd[20:5]);
    end
    repeat (3) drive(fault_v, 1'b0, 1'b0, 3'h0, 16'h0000);
    complete_run();
  end
endmodule : testbench
